// ===== include/alt_function_remap_pkg.sv
// constants, field layout and pin carriers for the remap and compensation block
package alt_function_remap_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  localparam logic [ADDR_W-1:0] REMAP_CTRL_OFFSET = 8'h1C;
  localparam logic [ADDR_W-1:0] COMP_CTRL_OFFSET = 8'h20;

  localparam logic [DATA_W-1:0] REMAP_CTRL_RESET = 32'h00000000;
  localparam logic [DATA_W-1:0] COMP_CTRL_RESET = 32'h00000000;

  // bits that software may change; all others read as zero, except the compensation ready bit, which reads live status
  localparam logic [DATA_W-1:0] REMAP_CTRL_WR_MASK = 32'h00001FE0;
  localparam logic [DATA_W-1:0] COMP_CTRL_WR_MASK = 32'h00000001;

  localparam int TRIM_SEL_LSB = 11;
  localparam int TRIM_SEL_MSB = 12;
  localparam int ADDR_VALID_DISC_BIT = 10;
  localparam int TIMER13_SEL_BIT = 9;
  localparam int TIMER12_SEL_BIT = 8;
  localparam int TIMER10_SEL_BIT = 7;
  localparam int TIMER9_SEL_BIT = 6;
  localparam int TIMER8_SEL_BIT = 5;
  // single-channel selects sit side by side: timers 9, 10, 12, 13
  localparam int SINGLE_SEL_LSB = 6;
  localparam int SINGLE_TIMERS = 4;

  localparam int COMP_READY_BIT = 8;
  localparam int COMP_ENABLE_BIT = 0;

  localparam logic [1:0] TRIM_SEL_PA8 = 2'h0;
  localparam logic [1:0] TRIM_SEL_PD15 = 2'h1;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    REG_NONE = 2'h0,
    REG_REMAP = 2'h1,
    REG_COMP = 2'h3
  } reg_sel_t;

  typedef struct packed {
    logic value;
    logic oe;
  } pin_drive_t;

  typedef struct packed {
    logic pa8;
    logic pd15;
    logic pf0;
  } trim_pins_t;

  typedef struct packed {
    logic ch0;
    logic ch1;
  } dual_channel_t;

  typedef struct packed {
    pin_drive_t pa2;
    pin_drive_t pa3;
    pin_drive_t pe5;
    pin_drive_t pe6;
  } timer8_pins_t;

endpackage : alt_function_remap_pkg

// ===== hdl/level_sync.sv
// two-flop synchroniser for a slow level
`timescale 1ns/1ns
`default_nettype none
module level_sync
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic async_in,
  output logic sync_out
);

  logic meta_q;
  logic sync_q;

  // first stage feeds only the second stage
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end
    else
    begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;

endmodule : level_sync
`default_nettype wire

// ===== hdl/alt_function_remap_and_io_comp.sv
// pin remap control and compensation cell control over an axi4-lite slave
//
// Our own choice: the AXI4-Lite slave port.
`timescale 1ns/1ns
`default_nettype none
module alt_function_remap_and_io_comp
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [7:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  input wire alt_function_remap_pkg::trim_pins_t trim_pins,
  output logic trim_sync_input,
  input wire logic ext_mem_addr_valid_strobe,
  output alt_function_remap_pkg::pin_drive_t addr_valid_pin,
  input wire logic [3:0] single_channel0,
  output alt_function_remap_pkg::pin_drive_t [3:0] single_default_pin,
  output alt_function_remap_pkg::pin_drive_t [3:0] single_remap_pin,
  input wire alt_function_remap_pkg::dual_channel_t timer_unit8_channels,
  output alt_function_remap_pkg::timer8_pins_t timer8_pins,
  output logic comp_cell_enable,
  input wire logic comp_cell_ready_in
);

  logic [31:0] remap_q;
  logic [31:0] comp_q;
  logic aw_held_q;
  logic w_held_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic ready_sync;
  logic comp_ready_flag;
  logic wr_commit;
  logic ar_fire;
  alt_function_remap_pkg::reg_sel_t wr_sel;
  alt_function_remap_pkg::reg_sel_t rd_sel;

  // address decode, shared by read and write paths
  function automatic alt_function_remap_pkg::reg_sel_t decode(
    input logic [7:0] addr
  );
    alt_function_remap_pkg::reg_sel_t sel;
    sel = alt_function_remap_pkg::REG_NONE;
    if (addr == alt_function_remap_pkg::REMAP_CTRL_OFFSET)
    begin
      sel = alt_function_remap_pkg::REG_REMAP;
    end
    else if (addr == alt_function_remap_pkg::COMP_CTRL_OFFSET)
    begin
      sel = alt_function_remap_pkg::REG_COMP;
    end
    return sel;
  endfunction : decode

  // byte-lane merge limited to writable bits
  function automatic logic [31:0] merge(
    input logic [31:0] old,
    input logic [31:0] data,
    input logic [3:0] strb,
    input logic [31:0] mask
  );
    logic [31:0] lanes;
    lanes = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    return ((old & ~lanes) | (data & lanes)) & mask;
  endfunction : merge

  // write channel: address and data taken in either order
  assign s_axi_awready = !aw_held_q;
  assign s_axi_wready = !w_held_q;
  assign wr_commit = aw_held_q && w_held_q && !bvalid_q;
  assign wr_sel = decode(awaddr_q);

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      aw_held_q <= 1'b0;
      awaddr_q <= 8'h00;
    end
    else if (s_axi_awvalid && s_axi_awready)
    begin
      aw_held_q <= 1'b1;
      awaddr_q <= s_axi_awaddr;
    end
    else if (wr_commit)
    begin
      aw_held_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      w_held_q <= 1'b0;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
    end
    else if (s_axi_wvalid && s_axi_wready)
    begin
      w_held_q <= 1'b1;
      wdata_q <= s_axi_wdata;
      wstrb_q <= s_axi_wstrb;
    end
    else if (wr_commit)
    begin
      w_held_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bvalid_q <= 1'b0;
      bresp_q <= alt_function_remap_pkg::RESP_OKAY;
    end
    else if (wr_commit)
    begin
      bvalid_q <= 1'b1;
      if (wr_sel == alt_function_remap_pkg::REG_NONE)
      begin
        bresp_q <= alt_function_remap_pkg::RESP_SLVERR;
      end
      else
      begin
        bresp_q <= alt_function_remap_pkg::RESP_OKAY;
      end
    end
    else if (s_axi_bready)
    begin
      bvalid_q <= 1'b0;
    end
  end

  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;

  // remap register storage
  // reserved bits are masked off, so a careless write cannot set them
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      remap_q <= alt_function_remap_pkg::REMAP_CTRL_RESET;
    end
    else if (wr_commit && wr_sel == alt_function_remap_pkg::REG_REMAP)
    begin
      remap_q <= merge(remap_q, wdata_q, wstrb_q,
                       alt_function_remap_pkg::REMAP_CTRL_WR_MASK);
    end
  end

  // ready bit is not stored here, so writes never reach it
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      comp_q <= alt_function_remap_pkg::COMP_CTRL_RESET;
    end
    else if (wr_commit && wr_sel == alt_function_remap_pkg::REG_COMP)
    begin
      comp_q <= merge(comp_q, wdata_q, wstrb_q,
                      alt_function_remap_pkg::COMP_CTRL_WR_MASK);
    end
  end

  // read channel: one read outstanding, answer one cycle after address
  assign s_axi_arready = !rvalid_q;
  assign ar_fire = s_axi_arvalid && s_axi_arready;
  assign rd_sel = decode(s_axi_araddr);

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= alt_function_remap_pkg::RESP_OKAY;
    end
    else if (ar_fire)
    begin
      rvalid_q <= 1'b1;
      rresp_q <= alt_function_remap_pkg::RESP_OKAY;
      case (rd_sel)
        alt_function_remap_pkg::REG_REMAP: rdata_q <= remap_q;
        alt_function_remap_pkg::REG_COMP:
        begin
          rdata_q <= comp_q;
          // live ready status at its bit
          rdata_q[alt_function_remap_pkg::COMP_READY_BIT] <= comp_ready_flag;
        end
        default:
        begin
          rdata_q <= 32'h00000000;
          rresp_q <= alt_function_remap_pkg::RESP_SLVERR;
        end
      endcase
    end
    else if (s_axi_rready)
    begin
      rvalid_q <= 1'b0;
    end
  end

  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  // enable straight from the stored bit
  assign comp_cell_enable = comp_q[alt_function_remap_pkg::COMP_ENABLE_BIT];

  // the analogue cell settles on its own time base
  level_sync u_ready_sync
  (
    .clk(clk),
    .rst_n(rst_n),
    .async_in(comp_cell_ready_in),
    .sync_out(ready_sync)
  );

  // gated by enable
  // a stale ready from a disabled cell would otherwise mislead software
  assign comp_ready_flag = ready_sync && comp_cell_enable;

  always_comb
  begin
    case (remap_q[alt_function_remap_pkg::TRIM_SEL_MSB:
                  alt_function_remap_pkg::TRIM_SEL_LSB])
      alt_function_remap_pkg::TRIM_SEL_PA8: trim_sync_input = trim_pins.pa8;
      alt_function_remap_pkg::TRIM_SEL_PD15: trim_sync_input = trim_pins.pd15;
      default: trim_sync_input = trim_pins.pf0;
    endcase
  end

  assign addr_valid_pin.oe =
    !remap_q[alt_function_remap_pkg::ADDR_VALID_DISC_BIT];
  assign addr_valid_pin.value = addr_valid_pin.oe && ext_mem_addr_valid_strobe;

  // single-channel pin pairs, one select bit each
  genvar gi;
  generate
    for (gi = 0; gi < alt_function_remap_pkg::SINGLE_TIMERS; gi++)
    begin : g_single
      logic sel;
      assign sel = remap_q[alt_function_remap_pkg::SINGLE_SEL_LSB + gi];
      assign single_default_pin[gi].oe = !sel;
      assign single_default_pin[gi].value = !sel && single_channel0[gi];
      assign single_remap_pin[gi].oe = sel;
      assign single_remap_pin[gi].value = sel && single_channel0[gi];
    end
  endgenerate

  logic t8_sel;
  assign t8_sel = remap_q[alt_function_remap_pkg::TIMER8_SEL_BIT];
  assign timer8_pins.pa2.oe = !t8_sel;
  assign timer8_pins.pa2.value = !t8_sel && timer_unit8_channels.ch0;
  assign timer8_pins.pa3.oe = !t8_sel;
  assign timer8_pins.pa3.value = !t8_sel && timer_unit8_channels.ch1;
  assign timer8_pins.pe5.oe = t8_sel;
  assign timer8_pins.pe5.value = t8_sel && timer_unit8_channels.ch0;
  assign timer8_pins.pe6.oe = t8_sel;
  assign timer8_pins.pe6.value = t8_sel && timer_unit8_channels.ch1;

  // checks
  property p_trim_select;
    @(posedge clk) disable iff (!rst_n)
    remap_q[12:11] == 2'h1 |-> trim_sync_input == trim_pins.pd15;
  endproperty
  a_trim_select: assert property (p_trim_select)
    else $error("trim sync not taken from PD15");

  property p_strobe_release;
    @(posedge clk) disable iff (!rst_n)
    remap_q[10] |-> !addr_valid_pin.oe && !addr_valid_pin.value;
  endproperty
  a_strobe_release: assert property (p_strobe_release)
    else $error("strobe pin driven while disconnected");

  property p_timer13_map;
    @(posedge clk) disable iff (!rst_n)
    remap_q[9] |-> single_remap_pin[3].oe && !single_default_pin[3].oe
      && single_remap_pin[3].value == single_channel0[3];
  endproperty
  a_timer13_map: assert property (p_timer13_map)
    else $error("timer 13 channel not on PF9");

  property p_timer9_map;
    @(posedge clk) disable iff (!rst_n)
    !remap_q[6] |-> single_default_pin[0].oe
      && single_default_pin[0].value == single_channel0[0];
  endproperty
  a_timer9_map: assert property (p_timer9_map)
    else $error("timer 9 channel not on PB8");

  property p_timer8_map;
    @(posedge clk) disable iff (!rst_n)
    remap_q[5] |-> timer8_pins.pe6.value == timer_unit8_channels.ch1
      && !timer8_pins.pa3.oe;
  endproperty
  a_timer8_map: assert property (p_timer8_map)
    else $error("timer 8 channel 1 not on PE6");

  property p_remap_write;
    @(posedge clk) disable iff (!rst_n)
    wr_commit && awaddr_q == 8'h1C && wstrb_q == 4'hF
      |=> remap_q == ($past(wdata_q) & 32'h00001FE0);
  endproperty
  a_remap_write: assert property (p_remap_write)
    else $error("remap register did not take write");

  property p_ready_read;
    @(posedge clk) disable iff (!rst_n)
    ar_fire && s_axi_araddr == 8'h20 |=> s_axi_rvalid
      && s_axi_rdata[8] == $past(comp_ready_flag);
  endproperty
  a_ready_read: assert property (p_ready_read)
    else $error("read ready bit mismatch");

  property p_enable_write;
    @(posedge clk) disable iff (!rst_n)
    wr_commit && awaddr_q == 8'h20 && wstrb_q[0]
      |=> comp_cell_enable == $past(wdata_q[0]);
  endproperty
  a_enable_write: assert property (p_enable_write)
    else $error("enable did not follow write");

  property p_enable_stable;
    @(posedge clk) disable iff (!rst_n)
    $changed(comp_cell_enable) |-> $past(wr_commit)
      && $past(awaddr_q) == 8'h20;
  endproperty
  a_enable_stable: assert property (p_enable_stable)
    else $error("enable changed without a write");

  property p_timer12_map;
    @(posedge clk) disable iff (!rst_n)
    remap_q[8] != remap_q[7] |-> single_remap_pin[2].oe
      != single_remap_pin[1].oe;
  endproperty
  a_timer12_map: assert property (p_timer12_map)
    else $error("timer 12 and 10 selects crossed");

  property p_ready_sync;
    @(posedge clk) disable iff (!rst_n)
    comp_cell_enable && comp_cell_ready_in [*3]
      |-> comp_ready_flag;
  endproperty
  a_ready_sync: assert property (p_ready_sync)
    else $error("ready flag late");

  property p_ready_gated;
    @(posedge clk) disable iff (!rst_n)
    !comp_cell_enable |-> !comp_ready_flag;
  endproperty
  a_ready_gated: assert property (p_ready_gated)
    else $error("ready flag set while disabled");

  property p_cov_remap_all;
    @(posedge clk) disable iff (!rst_n)
    remap_q[12:5] == 8'hFF;
  endproperty
  c_cov_remap_all: cover property (p_cov_remap_all);

  property p_cov_ready;
    @(posedge clk) disable iff (!rst_n)
    $rose(comp_ready_flag);
  endproperty
  c_cov_ready: cover property (p_cov_ready);

  property p_cov_bad_addr;
    @(posedge clk) disable iff (!rst_n)
    s_axi_rvalid && s_axi_rresp == 2'h2;
  endproperty
  c_cov_bad_addr: cover property (p_cov_bad_addr);

endmodule : alt_function_remap_and_io_comp
`default_nettype wire

// ===== verification/alt_function_remap_and_io_comp_tb_top.sv
// self-checking bench for the remap and compensation register block
`timescale 1ns/1ns
`default_nettype none
module alt_function_remap_and_io_comp_tb_top;
  logic clk, rst_n;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  alt_function_remap_pkg::trim_pins_t trim_pins;
  logic trim_sync_input, ext_mem_addr_valid_strobe;
  alt_function_remap_pkg::pin_drive_t addr_valid_pin;
  logic [3:0] single_channel0;
  alt_function_remap_pkg::pin_drive_t [3:0] single_default_pin;
  alt_function_remap_pkg::pin_drive_t [3:0] single_remap_pin;
  alt_function_remap_pkg::dual_channel_t timer_unit8_channels;
  alt_function_remap_pkg::timer8_pins_t timer8_pins;
  logic comp_cell_enable, comp_cell_ready_in;
  int n_errors, num_checks, k;
  logic [31:0] seed, r;
  logic [33:0] exp_r[$];
  logic [1:0] exp_b[$];

  alt_function_remap_and_io_comp u_dut (
    .clk(clk), .rst_n(rst_n),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .trim_pins(trim_pins),
    .trim_sync_input(trim_sync_input),
    .ext_mem_addr_valid_strobe(ext_mem_addr_valid_strobe),
    .addr_valid_pin(addr_valid_pin), .single_channel0(single_channel0),
    .single_default_pin(single_default_pin),
    .single_remap_pin(single_remap_pin),
    .timer_unit8_channels(timer_unit8_channels),
    .timer8_pins(timer8_pins), .comp_cell_enable(comp_cell_enable),
    .comp_cell_ready_in(comp_cell_ready_in)
  );

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic stop_test;
    if (n_errors == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : stop_test

  task automatic check(input logic [33:0] seen, input logic [33:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("Error %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  // a wait that runs out ends the run at once
  task automatic wait_lost;
    n_errors++;
    $display("Error %0t: handshake never completed", $time);
    stop_test();
  endtask : wait_lost

  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs

  task automatic axi_write(input logic [7:0] a, input logic [31:0] d,
    input logic [1:0] resp);
    int n;
    exp_b.push_back(resp);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hF;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge clk);
      if (s_axi_awvalid && s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
        s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid)
        break;
    end
    s_axi_bready <= 1'b0;
    if (n == 50)
      wait_lost();
    // one idle edge so the next request never lands in this time step
    @(posedge clk);
  endtask : axi_write

  task automatic axi_read(input logic [7:0] a, input logic [33:0] e);
    int n;
    exp_r.push_back(e);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge clk);
      if (s_axi_arvalid && s_axi_arready)
        s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid)
        break;
    end
    s_axi_rready <= 1'b0;
    if (n == 50)
      wait_lost();
    @(posedge clk);
  endtask : axi_read

  // responses are matched in order against the notes of the drivers
  always @(posedge clk)
  begin
    if (s_axi_rvalid && s_axi_rready && exp_r.size() > 0)
      check({s_axi_rresp, s_axi_rdata}, exp_r.pop_front());
    else if (s_axi_rvalid && s_axi_rready)
      check(34'h3FFFFFFFF, 34'h0); // unexpected read answer
    if (s_axi_bvalid && s_axi_bready && exp_b.size() > 0)
      check({32'h0, s_axi_bresp}, {32'h0, exp_b.pop_front()});
    else if (s_axi_bvalid && s_axi_bready)
      check(34'h3FFFFFFFF, 34'h0); // unexpected write answer
  end

  task automatic rand_inputs;
    seed = xs(seed);
    trim_pins <= seed[2:0];
    ext_mem_addr_valid_strobe <= seed[3];
    single_channel0 <= seed[7:4];
    timer_unit8_channels <= seed[9:8];
  endtask : rand_inputs

  task automatic check_pins(input logic [31:0] v);
    alt_function_remap_pkg::pin_drive_t [3:0] dflt, rmp;
    alt_function_remap_pkg::timer8_pins_t t8;
    alt_function_remap_pkg::pin_drive_t av;
    logic tr, c0, c1, m;
    logic [3:0] s;
    int i;
    s = {v[9], v[8], v[7], v[6]};
    for (i = 0; i < 4; i++)
    begin
      dflt[i] = {single_channel0[i] & ~s[i], ~s[i]};
      rmp[i] = {single_channel0[i] & s[i], s[i]};
    end
    av = {ext_mem_addr_valid_strobe & ~v[10], ~v[10]};
    c0 = timer_unit8_channels.ch0;
    c1 = timer_unit8_channels.ch1;
    m = v[5];
    t8 = {c0 & ~m, ~m, c1 & ~m, ~m, c0 & m, m, c1 & m, m};
    case (v[12:11])
      2'h0: tr = trim_pins.pa8;
      2'h1: tr = trim_pins.pd15;
      default: tr = trim_pins.pf0;
    endcase
    check({7'h0, trim_sync_input, addr_valid_pin, single_default_pin,
      single_remap_pin, timer8_pins}, {7'h0, tr, av, dflt, rmp, t8});
  endtask : check_pins

  initial
  begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready, comp_cell_ready_in} = 3'h0;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'h0;
    trim_pins = 3'h0;
    ext_mem_addr_valid_strobe = 1'b0;
    single_channel0 = 4'h0;
    timer_unit8_channels = 2'h0;
    n_errors = 0;
    num_checks = 0;
    seed = 32'h000064A5;
    rst_n = 1'b0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    check_pins(32'h0);
    axi_read(alt_function_remap_pkg::REMAP_CTRL_OFFSET, 34'h0);
    axi_read(alt_function_remap_pkg::COMP_CTRL_OFFSET, 34'h0);
    // every trim code and a spread of select bits, random pin levels
    for (k = 0; k < 16; k++)
    begin
      seed = xs(seed);
      r = seed & alt_function_remap_pkg::REMAP_CTRL_WR_MASK;
      r[12:11] = k[1:0];
      axi_write(alt_function_remap_pkg::REMAP_CTRL_OFFSET, r,
        alt_function_remap_pkg::RESP_OKAY);
      rand_inputs();
      @(posedge clk);
      check_pins(r);
      axi_read(alt_function_remap_pkg::REMAP_CTRL_OFFSET, {2'h0, r});
    end
    // ready from the cell is masked while the cell is off
    comp_cell_ready_in <= 1'b1;
    repeat (4) @(posedge clk);
    axi_read(alt_function_remap_pkg::COMP_CTRL_OFFSET, 34'h0);
    // cell switched on before fast outputs
    axi_write(alt_function_remap_pkg::COMP_CTRL_OFFSET, 32'h1,
      alt_function_remap_pkg::RESP_OKAY);
    check({33'h0, comp_cell_enable}, 34'h1);
    repeat (4) @(posedge clk);
    axi_read(alt_function_remap_pkg::COMP_CTRL_OFFSET, 34'h101);
    comp_cell_ready_in <= 1'b0;
    repeat (4) @(posedge clk);
    axi_read(alt_function_remap_pkg::COMP_CTRL_OFFSET, 34'h1);
    // a write to the read-only flag must not stick
    axi_write(alt_function_remap_pkg::COMP_CTRL_OFFSET, 32'h100,
      alt_function_remap_pkg::RESP_OKAY);
    check({33'h0, comp_cell_enable}, 34'h0);
    axi_read(alt_function_remap_pkg::COMP_CTRL_OFFSET, 34'h0);
    axi_write(alt_function_remap_pkg::COMP_CTRL_OFFSET, 32'h1,
      alt_function_remap_pkg::RESP_OKAY);
    // unmapped place: refused, nothing disturbed
    axi_write(8'h24, 32'hFFFFFFFF, alt_function_remap_pkg::RESP_SLVERR);
    axi_read(8'h24, {alt_function_remap_pkg::RESP_SLVERR, 32'h0});
    axi_read(alt_function_remap_pkg::REMAP_CTRL_OFFSET, {2'h0, r});
    // reset in mid-run brings both registers back to zero
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    check({33'h0, comp_cell_enable}, 34'h0);
    check_pins(32'h0);
    axi_read(alt_function_remap_pkg::REMAP_CTRL_OFFSET, 34'h0);
    axi_read(alt_function_remap_pkg::COMP_CTRL_OFFSET, 34'h0);
    stop_test();
  end
endmodule : alt_function_remap_and_io_comp_tb_top
`default_nettype wire
